//--- adp_pkg.sv
/*
  Shared constants and types of the audio core datapath.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package adp_pkg;
  localparam int WORD_W = 32;
  localparam int FRAC_W = 24;
  localparam int COEF_W = 64;
  localparam int PROD_W = COEF_W + WORD_W;
  localparam int ACC_W = 80;
  localparam int LANES = 4;
  localparam int LINE_W = 256;
  localparam int SER_W = 24;
  localparam int OUT_W = 2 * SER_W;
  localparam int NACC = 16;
  localparam int NDAG = 16;
  localparam int SEL_W = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = LANES * WORD_W;
  localparam int PROD_SHIFT = 24;
  localparam int ACC_DROP = 32;
  localparam int HEAD_W = 8;
  localparam int WORK_W = 56;
  localparam int REM_W = 58;
  localparam int CNT_W = 6;
  localparam int SHAMT_W = 6;
  localparam int EXP_MAX = 7;
  localparam int EXP_MIN = -25;
  localparam logic [CNT_W-1:0] DIV_STEPS = 6'h38;
  localparam logic [CNT_W-1:0] SQRT_STEPS = 6'h1c;
  localparam int CYC_PER_SAMPLE = 6144;
  localparam int FRAME_W = 13;
  localparam logic [31:0] LFSR_TAPS = 32'h80200003;
  localparam logic [31:0] LFSR_SEED = 32'h00000001;
  localparam logic [31:0] MAX_CORE = 32'h7fffffff;
  localparam logic [31:0] MIN_CORE = 32'h80000000;
  localparam logic [23:0] MAX_OUT = 24'h7fffff;
  localparam logic [23:0] MIN_OUT = 24'h800000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 24'h000000;

  typedef enum logic [3:0] {
    OP_CLR = 4'h0, OP_MAC = 4'h1, OP_LOAD = 4'h2, OP_STORE = 4'h3,
    OP_DAGSET = 4'h4, OP_OUT = 4'h5, OP_IN = 4'h6, OP_DIV = 4'h7,
    OP_SQRT = 4'h8, OP_SHIFT = 4'h9, OP_LOG2 = 4'ha, OP_EXP2 = 4'hb,
    OP_SLEW = 4'hc, OP_RAND = 4'hd, OP_NOP0 = 4'he, OP_NOP1 = 4'hf
  } adp_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_ITER = 2'b11, ST_WAIT = 2'b10
  } adp_state_e;
endpackage
`default_nettype wire

//--- adp_acc_bank.sv
/*
  Bank of accumulator registers with two registered reads and two writes.
  Assumes the two write addresses differ whenever both enables are high.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_acc_bank (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [adp_pkg::SEL_W-1:0] rdAddr0,
  input wire logic [adp_pkg::SEL_W-1:0] rdAddr1,
  output logic [adp_pkg::ACC_W-1:0] rdData0,
  output logic [adp_pkg::ACC_W-1:0] rdData1,
  input wire logic wrEn0,
  input wire logic wrEn1,
  input wire logic [adp_pkg::SEL_W-1:0] wrAddr0,
  input wire logic [adp_pkg::SEL_W-1:0] wrAddr1,
  input wire logic [adp_pkg::ACC_W-1:0] wrData0,
  input wire logic [adp_pkg::ACC_W-1:0] wrData1
);
  import adp_pkg::*;
  logic [ACC_W-1:0] mem_q [NACC];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdData0 <= '0;
      rdData1 <= '0;
    end else begin
      rdData0 <= mem_q[rdAddr0];
      rdData1 <= mem_q[rdAddr1];
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NACC; i++) begin
      if (sys_rst) begin
        mem_q[i] <= '0;
      end else if (wrEn0 && wrAddr0 == SEL_W'(i)) begin
        mem_q[i] <= wrData0;
      end else if (wrEn1 && wrAddr1 == SEL_W'(i)) begin
        mem_q[i] <= wrData1;
      end
    end
  end
endmodule
`default_nettype wire

//--- adp_skid_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes the drain side may stall for any time.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_skid_buf #(
  parameter int W = adp_pkg::OUT_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  logic [W-1:0] slot_q [2];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = slot_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr_q <= 1'h0;
      rdPtr_q <= 1'h0;
      count_q <= 2'h0;
    end else begin
      wrPtr_q <= wrPtr_q ^ push;
      rdPtr_q <= rdPtr_q ^ pop;
      count_q <= count_q + {1'h0, push} - {1'h0, pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
    end else if (push) begin
      slot_q[wrPtr_q] <= inData;
    end
  end
endmodule
`default_nettype wire

//--- adp_datapath.sv
/*
  Fixed-point datapath of the audio core: SIMD multiply-accumulate,
  line load/store with circular address generators, accelerators and
  the output clipper feeding the two-entry serial output buffer.
  Assumes memory answers a load with memRdValid at least a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_datapath #(
  parameter int CYC_SAMPLE = adp_pkg::CYC_PER_SAMPLE
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic opValid,
  output logic opReady,
  input wire adp_pkg::adp_op_e opCode,
  input wire logic [adp_pkg::SEL_W-1:0] opAcc,
  input wire logic [adp_pkg::SEL_W-1:0] opDag,
  input wire logic [adp_pkg::DATA_W-1:0] opData,
  input wire logic [adp_pkg::ADDR_W-1:0] opAddr,
  input wire logic [adp_pkg::ADDR_W-1:0] opLen,
  input wire logic [adp_pkg::ADDR_W-1:0] opStep,
  output logic resValid,
  output logic [adp_pkg::WORD_W-1:0] resData,
  output logic memReq,
  output logic memWrite,
  output logic [adp_pkg::ADDR_W-1:0] memAddr,
  output logic [adp_pkg::LINE_W-1:0] memWrData,
  input wire logic memRdValid,
  input wire logic [adp_pkg::LINE_W-1:0] memRdData,
  output logic outValid,
  input wire logic outReady,
  output logic [adp_pkg::OUT_W-1:0] outData,
  output logic frameTick
);
  import adp_pkg::*;

  // ----------------------------------------------------------------
  // Number format helpers
  // ----------------------------------------------------------------
  // Converts a 24.56 accumulator to an 8.24 word with saturation.
  function automatic logic [WORD_W-1:0] accToCore(input logic [ACC_W-1:0] a);
    logic [ACC_W-1:0] hi;
    hi = a >> (ACC_DROP + WORD_W - 1);
    if (hi == '0 || hi == (ACC_W'('1) >> (ACC_DROP + WORD_W - 1))) begin
      accToCore = a[ACC_DROP +: WORD_W];
    end else begin
      accToCore = a[ACC_W-1] ? MIN_CORE : MAX_CORE;
    end
  endfunction

  // Clips an 8.24 word to a 1.23 serial word instead of wrapping.
  function automatic logic [SER_W-1:0] clipOut(input logic [WORD_W-1:0] x);
    logic [HEAD_W:0] top;
    top = x[WORD_W-1 -: HEAD_W+1];
    if (top == '0 || top == '1) begin
      clipOut = x[SER_W:1];
    end else begin
      clipOut = x[WORD_W-1] ? MIN_OUT : MAX_OUT;
    end
  endfunction

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  adp_state_e state_q;
  adp_op_e op_q;
  logic [SEL_W-1:0] acc_q;
  logic [SEL_W-1:0] dag_q;
  logic [DATA_W-1:0] dat_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] len_q;
  logic [ADDR_W-1:0] step_q;
  logic [CNT_W-1:0] cnt_q;
  logic bufInReady;
  logic accept;
  logic inExec;

  assign opReady = (state_q == ST_IDLE) && (opCode != OP_OUT || bufInReady);
  assign accept = opValid && opReady;
  assign inExec = (state_q == ST_EXEC);

  // One instruction steers all lanes of the datapath at once.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (op_q == OP_DIV || op_q == OP_SQRT) begin
            state_q <= ST_ITER;
          end else if (op_q == OP_LOAD) begin
            state_q <= ST_WAIT;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_ITER: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (memRdValid) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_q <= OP_NOP0;
      acc_q <= '0;
      dag_q <= '0;
      dat_q <= '0;
      addr_q <= '0;
      len_q <= '0;
      step_q <= '0;
    end else if (accept) begin
      op_q <= opCode;
      acc_q <= opAcc;
      dag_q <= opDag;
      dat_q <= opData;
      addr_q <= opAddr;
      len_q <= opLen;
      step_q <= opStep;
    end
  end

  // ----------------------------------------------------------------
  // Multipliers and ALUs
  // ----------------------------------------------------------------
  logic [LINE_W-1:0] line_q;
  logic [ACC_W-1:0] accRd0;
  logic [ACC_W-1:0] accRd1;
  logic [ACC_W-1:0] prod [LANES];
  logic [ACC_W-1:0] alu0;
  logic [ACC_W-1:0] alu1;
  logic accWr;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gMul
      logic signed [PROD_W-1:0] p;
      // An 8.56 coefficient times an 8.24 sample, realigned to 24.56.
      assign p = $signed(line_q[g*COEF_W +: COEF_W]) * $signed(dat_q[g*WORD_W +: WORD_W]);
      assign prod[g] = ACC_W'(p >>> PROD_SHIFT);
    end
  endgenerate

  // Each ALU adds a pair of products onto its accumulator in 24.56.
  assign alu0 = (op_q == OP_CLR) ? '0 : accRd0 + prod[0] + prod[1];
  assign alu1 = (op_q == OP_CLR) ? '0 : accRd1 + prod[2] + prod[3];
  assign accWr = inExec && (op_q == OP_MAC || op_q == OP_CLR);

  adp_acc_bank uAcc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .rdAddr0(opAcc),
    .rdAddr1(opAcc + SEL_W'(1)),
    .rdData0(accRd0),
    .rdData1(accRd1),
    .wrEn0(accWr),
    .wrEn1(accWr),
    .wrAddr0(acc_q),
    .wrAddr1(acc_q + SEL_W'(1)),
    .wrData0(alu0),
    .wrData1(alu1)
  );

  // ----------------------------------------------------------------
  // Address generators and line memory port
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] dagBase_q [NDAG];
  logic [ADDR_W-1:0] dagLen_q [NDAG];
  logic [ADDR_W-1:0] dagPtr_q [NDAG];
  logic [ADDR_W:0] nextPtr;
  logic [ADDR_W:0] endPtr;
  logic memOp;

  assign memOp = inExec && (op_q == OP_LOAD || op_q == OP_STORE);
  assign nextPtr = {1'h0, dagPtr_q[dag_q]} + {1'h0, step_q};
  assign endPtr = {1'h0, dagBase_q[dag_q]} + {1'h0, dagLen_q[dag_q]};

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NDAG; i++) begin
      if (sys_rst) begin
        dagBase_q[i] <= '0;
        dagLen_q[i] <= '0;
        dagPtr_q[i] <= '0;
      end else if (inExec && op_q == OP_DAGSET && dag_q == SEL_W'(i)) begin
        dagBase_q[i] <= addr_q;
        dagLen_q[i] <= len_q;
        dagPtr_q[i] <= addr_q;
      end else if (memOp && dag_q == SEL_W'(i)) begin
        if (nextPtr >= endPtr) begin
          dagPtr_q[i] <= ADDR_W'(nextPtr - {1'h0, dagLen_q[i]});
        end else begin
          dagPtr_q[i] <= ADDR_W'(nextPtr);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      memReq <= 1'h0;
      memWrite <= 1'h0;
      memAddr <= '0;
      memWrData <= '0;
    end else begin
      memReq <= memOp;
      memWrite <= memOp && op_q == OP_STORE;
      if (memOp) begin
        memAddr <= dagPtr_q[dag_q];
      end
      if (memOp && op_q == OP_STORE) begin
        // Two accumulators, each sign-extended over four words.
        memWrData <= {{(LINE_W/2-ACC_W){accRd1[ACC_W-1]}}, accRd1,
                      {(LINE_W/2-ACC_W){accRd0[ACC_W-1]}}, accRd0};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_q <= '0;
    end else if (state_q == ST_WAIT && memRdValid) begin
      line_q <= memRdData;
    end
  end

  // ----------------------------------------------------------------
  // Output clipper and buffer
  // ----------------------------------------------------------------
  logic [OUT_W-1:0] clipPair;
  assign clipPair = {clipOut(accToCore(accRd1)), clipOut(accToCore(accRd0))};

  adp_skid_buf #(.W(OUT_W)) uBuf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(inExec && op_q == OP_OUT),
    .inReady(bufInReady),
    .inData(clipPair),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outData)
  );

  // ----------------------------------------------------------------
  // Accelerators
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] opA;
  logic [WORD_W-1:0] opB;
  logic [WORD_W-1:0] magA;
  logic [WORD_W-1:0] magB;
  logic [WORK_W-1:0] work_q;
  logic [REM_W-1:0] rem_q;
  logic [WORK_W-1:0] quo_q;
  logic [REM_W-1:0] den_q;
  logic neg_q;
  logic [REM_W-1:0] remN;
  logic [REM_W-1:0] trial;
  logic [WORD_W-1:0] iterRes;

  // Parameters and samples are taken in 8.24 format, except the 1.23 word of OP_IN and the integer shift amount of OP_SHIFT.
  assign opA = dat_q[0 +: WORD_W];
  assign opB = dat_q[WORD_W +: WORD_W];
  assign magA = opA[WORD_W-1] ? WORD_W'(-opA) : opA;
  assign magB = opB[WORD_W-1] ? WORD_W'(-opB) : opB;
  assign remN = (op_q == OP_DIV) ? {rem_q[REM_W-2:0], work_q[WORK_W-1]}
                                 : {rem_q[REM_W-3:0], work_q[WORK_W-1 -: 2]};
  assign trial = (op_q == OP_DIV) ? den_q : {quo_q, 2'h1};

  // Divide and square root run one result bit per cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      work_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      neg_q <= 1'h0;
      cnt_q <= '0;
    end else if (inExec) begin
      rem_q <= '0;
      quo_q <= '0;
      den_q <= REM_W'(magB);
      neg_q <= opA[WORD_W-1] ^ opB[WORD_W-1];
      cnt_q <= (op_q == OP_DIV) ? DIV_STEPS : SQRT_STEPS;
      if (op_q == OP_DIV) begin
        work_q <= {magA, FRAC_ZERO};
      end else begin
        work_q <= opA[WORD_W-1] ? '0 : {opA, FRAC_ZERO};
      end
    end else if (state_q == ST_ITER && cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
      work_q <= (op_q == OP_DIV) ? work_q << 1 : work_q << 2;
      if (remN >= trial) begin
        rem_q <= remN - trial;
        quo_q <= {quo_q[WORK_W-2:0], 1'h1};
      end else begin
        rem_q <= remN;
        quo_q <= {quo_q[WORK_W-2:0], 1'h0};
      end
    end
  end

  always_comb begin
    iterRes = quo_q[WORD_W-1:0];
    if (op_q == OP_DIV) begin
      if (quo_q[WORK_W-1:WORD_W-1] != '0) begin
        iterRes = neg_q ? MIN_CORE : MAX_CORE;
      end else if (neg_q) begin
        iterRes = WORD_W'(-quo_q[WORD_W-1:0]);
      end
    end
  end

  logic [WORD_W-1:0] slew_q;
  logic [WORD_W-1:0] lfsr_q;
  logic [WORD_W:0] slewDiff;
  logic [WORD_W:0] slewDist;

  assign slewDiff = {opA[WORD_W-1], opA} - {slew_q[WORD_W-1], slew_q};
  assign slewDist = slewDiff[WORD_W] ? (WORD_W+1)'(-slewDiff) : slewDiff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slew_q <= '0;
    end else if (inExec && op_q == OP_SLEW) begin
      if (slewDist <= {1'h0, opB}) begin
        slew_q <= opA;
      end else if (slewDiff[WORD_W]) begin
        slew_q <= slew_q - opB;
      end else begin
        slew_q <= slew_q + opB;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lfsr_q <= LFSR_SEED;
    end else if (inExec && op_q == OP_RAND) begin
      lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
    end
  end

  logic [WORD_W-1:0] accelRes;
  logic signed [SHAMT_W-1:0] shAmt;
  logic signed [HEAD_W-1:0] expInt;
  logic [WORD_W-1:0] mant;
  logic [WORD_W-1:0] norm;
  logic [HEAD_W-1:0] msb;

  assign shAmt = opB[SHAMT_W-1:0];
  assign expInt = opA[WORD_W-1 -: HEAD_W];
  assign mant = {{(HEAD_W-1){1'h0}}, 1'h1, opA[FRAC_W-1:0]};

  always_comb begin
    msb = '0;
    for (int i = 0; i < WORD_W; i++) begin
      if (opA[i]) begin
        msb = HEAD_W'(i);
      end
    end
    norm = opA << (HEAD_W'(WORD_W - 1) - msb);
    accelRes = '0;
    unique case (op_q)
      OP_IN: accelRes = {{(HEAD_W-1){opA[SER_W-1]}}, opA[SER_W-1:0], 1'h0};
      OP_SHIFT: begin
        // Integer 32.0 shift: positive amounts go left, negative right.
        if (shAmt >= 0) begin
          accelRes = opA << shAmt;
        end else begin
          accelRes = WORD_W'($signed(opA) >>> (-shAmt));
        end
      end
      OP_LOG2: begin
        if (opA[WORD_W-1] || opA == '0) begin
          accelRes = MIN_CORE;
        end else begin
          accelRes = {HEAD_W'(msb - HEAD_W'(FRAC_W)), norm[WORD_W-2 -: FRAC_W]};
        end
      end
      OP_EXP2: begin
        if (expInt >= EXP_MAX) begin
          accelRes = MAX_CORE;
        end else if (expInt <= EXP_MIN) begin
          accelRes = '0;
        end else if (expInt >= 0) begin
          accelRes = mant << expInt;
        end else begin
          accelRes = mant >> (-expInt);
        end
      end
      OP_SLEW: accelRes = slew_q;
      OP_RAND: accelRes = lfsr_q;
      default: accelRes = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Result port and sample-period tick
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resValid <= 1'h0;
      resData <= '0;
    end else if (state_q == ST_ITER && cnt_q == '0) begin
      resValid <= 1'h1;
      resData <= iterRes;
    end else if (inExec && op_q >= OP_IN && op_q != OP_DIV && op_q != OP_SQRT && op_q <= OP_RAND) begin
      resValid <= 1'h1;
      resData <= accelRes;
    end else begin
      resValid <= 1'h0;
    end
  end

  logic [FRAME_W-1:0] frameCnt_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frameCnt_q <= '0;
      frameTick <= 1'h0;
    end else begin
      frameTick <= (frameCnt_q == FRAME_W'(CYC_SAMPLE - 1));
      frameCnt_q <= (frameCnt_q == FRAME_W'(CYC_SAMPLE - 1)) ? '0 : frameCnt_q + FRAME_W'(1);
    end
  end
endmodule
`default_nettype wire

//--- adp_datapath_sva.sv
/*
  Port timing checker of the audio core datapath.
  Assumes it is bound to every adp_datapath instance.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_datapath_chk #(
  parameter int CYC_SAMPLE = adp_pkg::CYC_PER_SAMPLE
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic opValid,
  input wire logic opReady,
  input wire adp_pkg::adp_op_e opCode,
  input wire logic [adp_pkg::DATA_W-1:0] opData,
  input wire logic resValid,
  input wire logic [adp_pkg::WORD_W-1:0] resData,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [adp_pkg::OUT_W-1:0] outData,
  input wire logic frameTick
);
  import adp_pkg::*;
  logic take;
  int gap_q;
  logic seen_q;
  assign take = opValid && opReady;
  always_ff @(posedge core_clk) begin
    if (sys_rst || frameTick) gap_q <= 0;
    else gap_q <= gap_q + 1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) seen_q <= 1'b0;
    else if (frameTick) seen_q <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_one_inflight: assert property (take |=> !opReady) else $error("accept while busy");
  a_result_pulse: assert property (resValid |=> !resValid) else $error("resValid too long");
  a_memreq_pulse: assert property (memReq |=> !memReq) else $error("memReq too long");
  a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("stalled word changed");
  a_frame_period: assert property (frameTick && seen_q |-> gap_q == CYC_SAMPLE - 1)
    else $error("frame period wrong");
  a_in_extend: assert property (take && opCode == OP_IN |-> ##2 resValid &&
    resData == {{7{$past(opData[23], 2)}}, $past(opData[23:0], 2), 1'b0}) else $error("input word wrong");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !outValid && !resValid && !memReq)
    else $error("outputs active at reset");
  a_mac_release: assert property (take && opCode == OP_MAC |-> ##2 (opReady || opCode == OP_OUT))
    else $error("MAC not done");
  a_div_latency: assert property (take && opCode == OP_DIV |-> ##59 resValid) else $error("divide late");
  a_mem_kind: assert property (take && (opCode == OP_LOAD || opCode == OP_STORE) |->
    ##2 memReq && (memWrite == ($past(opCode, 2) == OP_STORE))) else $error("memory access wrong");
endmodule
bind adp_datapath adp_datapath_chk #(.CYC_SAMPLE(CYC_SAMPLE)) adp_datapath_chk_inst (.core_clk, .sys_rst,
  .opValid, .opReady, .opCode, .opData, .resValid, .resData, .memReq, .memWrite, .outValid, .outReady,
  .outData, .frameTick);
`default_nettype wire

//--- adp_far_end.sv
/*
  Model of the memory and of the output stream consumer.
  Assumes the bench supplies the line and the stall level.
*/
`timescale 1ns/1ps
`default_nettype none
module adp_far_end (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic memReq,
  input wire logic memWrite,
  output logic memRdValid,
  output logic [adp_pkg::LINE_W-1:0] memRdData,
  input wire logic [adp_pkg::LINE_W-1:0] lineData,
  input wire logic outValid,
  output logic outReady,
  input wire logic [adp_pkg::OUT_W-1:0] outData,
  input wire logic stall,
  output logic [7:0] rxCnt,
  output logic [adp_pkg::OUT_W-1:0] rxLast
);
  import adp_pkg::*;
  logic [1:0] pend_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) pend_q <= 2'b00;
    else pend_q <= {pend_q[0], memReq && !memWrite};
  end
  assign memRdValid = pend_q[1];
  // The line is inverted outside the answer cycle so stale data never passes.
  assign memRdData = pend_q[1] ? lineData : ~lineData;
  assign outReady = !stall;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxCnt <= 8'h00;
      rxLast <= '0;
    end else if (outValid && outReady) begin
      rxCnt <= rxCnt + 8'h01;
      rxLast <= outData;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench of the audio core datapath.
  Assumes the checker binds itself and the far end model is adp_far_end.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adp_pkg::*;
  localparam int FRAME = 16;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic opValid = 1'b0;
  logic opReady, resValid, memReq, memWrite, memRdValid, outValid, outReady, frameTick;
  adp_op_e opCode = OP_NOP0;
  logic [SEL_W-1:0] opAcc = 4'h0;
  logic [SEL_W-1:0] opDag = 4'h3;
  logic [DATA_W-1:0] opData = '0;
  logic [ADDR_W-1:0] opAddr = 16'h0010;
  logic [ADDR_W-1:0] opLen = 16'h0002;
  logic [ADDR_W-1:0] opStep = 16'h0001;
  logic [WORD_W-1:0] resData;
  logic [ADDR_W-1:0] memAddr;
  logic [LINE_W-1:0] memWrData, memRdData;
  logic [LINE_W-1:0] lineData = {64'h0, 64'h0100000000000000, 64'h0, 64'h0100000000000000};
  logic [OUT_W-1:0] outData, rxLast;
  logic stall = 1'b0;
  logic [7:0] rxCnt;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  adp_datapath #(.CYC_SAMPLE(FRAME)) adp_datapath_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .opValid(opValid), .opReady(opReady), .opCode(opCode), .opAcc(opAcc), .opDag(opDag), .opData(opData),
    .opAddr(opAddr), .opLen(opLen), .opStep(opStep), .resValid(resValid), .resData(resData), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData), .memRdValid(memRdValid),
    .memRdData(memRdData), .outValid(outValid), .outReady(outReady), .outData(outData), .frameTick(frameTick));
  adp_far_end adp_far_end_inst (.core_clk(core_clk), .sys_rst(sys_rst), .memReq(memReq), .memWrite(memWrite),
    .memRdValid(memRdValid), .memRdData(memRdData), .lineData(lineData), .outValid(outValid),
    .outReady(outReady), .outData(outData), .stall(stall), .rxCnt(rxCnt), .rxLast(rxLast));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [LINE_W-1:0] seen, input logic [LINE_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input adp_op_e c, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    opCode = c;
    opData = d;
    opValid = 1'b1;
    while (opReady !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    opValid = 1'b0;
  endtask
  task automatic res(input string nm, input logic [WORD_W-1:0] e);
    int n;
    n = 0;
    while (resValid !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(nm, {resValid, resData}, {1'b1, e});
  endtask
  task automatic mem(input string nm, input logic [ADDR_W-1:0] e);
    int n;
    n = 0;
    while (memReq !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk(nm, {memReq, memAddr}, {1'b1, e});
  endtask
  task automatic t_reset();
    chk("ready", opReady, 1'b1);
    chk("out_valid", outValid, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_accel();
    op(OP_IN, 128'h00400000);
    res("in_pos", 32'h00800000);
    op(OP_IN, 128'h00800000);
    res("in_neg", 32'hff000000);
    op(OP_RAND, 128'h0);
    res("rand", 32'h00000001);
    op(OP_SHIFT, {64'h0, 32'h4, 32'h1});
    res("shl", 32'h00000010);
    op(OP_SHIFT, {64'h0, 32'h3c, 32'h100});
    res("shr", 32'h00000010);
    op(OP_DIV, {64'h0, 32'h02000000, 32'h01000000});
    res("div", 32'h00800000);
    op(OP_SQRT, 128'h04000000);
    res("sqrt", 32'h02000000);
    op(OP_LOG2, 128'h02000000);
    res("log2", 32'h01000000);
    op(OP_EXP2, 128'h01000000);
    res("exp2", 32'h02000000);
    op(OP_SLEW, {64'h0, 32'h00400000, 32'h01000000});
    res("slew_first", 32'h00000000);
    op(OP_SLEW, {64'h0, 32'h00400000, 32'h01000000});
    res("slew_step", 32'h00400000);
    $display("test accel done");
  endtask
  task automatic t_mac();
    op(OP_DAGSET, 128'h0);
    op(OP_LOAD, 128'h0);
    mem("load_addr", 16'h0010);
    opAcc = 4'h5;
    op(OP_MAC, {32'h0, 32'hfe000000, 32'h0, 32'h00400000});
    op(OP_STORE, 128'h0);
    mem("store_addr", 16'h0011);
    chk("store_lo", memWrData[127:0], {48'h0, 80'h00000040000000000000});
    chk("store_hi", memWrData[255:128], {48'hffffffffffff, 80'hfffffe00000000000000});
    op(OP_LOAD, 128'h0);
    mem("wrap_addr", 16'h0010);
    $display("test mac done");
  endtask
  task automatic t_out();
    stall = 1'b1;
    op(OP_OUT, 128'h0);
    op(OP_OUT, 128'h0);
    opCode = OP_OUT;
    opValid = 1'b1;
    repeat (3) begin
      @(negedge core_clk);
      chk("out_full", opReady, 1'b0);
    end
    chk("out_word", outData, {24'h800000, 24'h200000});
    opValid = 1'b0;
    stall = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("rx_cnt", rxCnt, 8'h02);
    chk("rx_word", rxLast, {24'h800000, 24'h200000});
    op(OP_CLR, 128'h0);
    op(OP_OUT, 128'h0);
    repeat (3) @(negedge core_clk);
    chk("rx_clr", {rxCnt, rxLast}, {8'h03, 48'h0});
    $display("test out done");
  endtask
  task automatic t_frame();
    int n;
    n = 0;
    while (frameTick !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (frameTick !== 1'b1 && n < 40);
    chk("frame", n, FRAME);
    $display("test frame done");
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_accel();
    t_mac();
    t_out();
    t_frame();
    final_report();
  end
endmodule
`default_nettype wire
